// [bench/scu_bus_master.sv]
// processor-side model of the register bus
`timescale 1ns/1ns
module scu_bus_master
(
  input wire logic clk_in,
  input wire logic ack_in,
  input wire logic [31:0] rdata_in,
  output logic req_out,
  output logic write_out,
  output logic [31:0] addr_out,
  output logic [31:0] wdata_out
);
  initial
  begin
    req_out = 1'b0;
    write_out = 1'b0;
    addr_out = 32'h0;
    wdata_out = 32'h0;
  end
  // one cycle request; firmware reads revision first
  task automatic access(input logic w, input logic [31:0] a,
    input logic [31:0] d, output logic ack, output logic [31:0] q);
    @(negedge clk_in);
    req_out = 1'b1;
    write_out = w;
    addr_out = a;
    wdata_out = d;
    @(negedge clk_in);
    ack = ack_in;
    q = rdata_in;
    req_out = 1'b0;
    // released address and data lines carry junk, never the last value
    addr_out = ~a;
    wdata_out = ~d;
  endtask
endmodule // scu_bus_master

// [bench/scu_system_control_assertions.sv]
// checker on the system control unit ports
`timescale 1ns/1ns
module scu_checker
#(
  parameter logic [31:0] UNIT_BASE = 32'h0000_8000,
  parameter logic [31:0] DETECTION_WORD = 32'h0000_1234,
  parameter logic [15:0] SYSTEM_TYPE = 16'h0001,
  parameter logic [31:0] HW_REVISION = 32'h0000_0004
)
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic req_in,
  input wire logic write_in,
  input wire logic [31:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic ack_out,
  input wire logic [31:0] rdata_out,
  input wire logic ext_sel_out,
  input wire logic [31:0] ext_addr_out,
  input wire logic [7:0] system_control_out,
  input wire logic [1:0] pclk_en_out
);
  logic hit;
  logic rd;
  logic ext;
  assign hit = req_in && addr_in[31:8] == UNIT_BASE[31:8];
  assign rd = hit && !write_in;
  assign ext = req_in && addr_in[31:16] == 16'h0001;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  unit_ack_a: assert property (hit |=> ack_out)
    else $error("unit request not acked");
  idle_rdata_a: assert property (!ack_out |-> rdata_out == 0)
    else $error("read data not zero when idle");
  ext_decode_a: assert property (ext |=> ext_sel_out && !ack_out
    && ext_addr_out == {16'h0, $past(addr_in[15:0])})
    else $error("external decode wrong");
  detect_read_a: assert property (rd && addr_in[5:0] == 6'h34
    |=> rdata_out == DETECTION_WORD) else $error("detection word wrong");
  type_read_a: assert property (rd && addr_in[5:0] == 6'h38
    |=> rdata_out == {16'h0, SYSTEM_TYPE}) else $error("type wrong");
  rev_alias_a: assert property (rd && addr_in[5:0] == 6'h3c
    |=> rdata_out == HW_REVISION) else $error("revision wrong");
  ctrl_write_a: assert property (hit && write_in && addr_in[5:0] == 0
    |=> system_control_out == $past(wdata_in[7:0]))
    else $error("control write lost");
  div_two_a: assert property (pclk_en_out[0]
    |=> !pclk_en_out[0] ##1 pclk_en_out[0]) else $error("divide 2 wrong");
  div_four_a: assert property (pclk_en_out[1]
    |=> !pclk_en_out[1] [*3] ##1 pclk_en_out[1]) else $error("divide 4");
  cover property (rd ##1 ack_out);
  cover property (hit && write_in);
  cover property (ext_sel_out);
endmodule // scu_checker
bind scu_system_control scu_checker #(.UNIT_BASE(UNIT_BASE),
  .DETECTION_WORD(DETECTION_WORD), .SYSTEM_TYPE(SYSTEM_TYPE),
  .HW_REVISION(HW_REVISION)) scu_checker_i (.clk_in(clk_in),
  .reset_n_in(reset_n_in), .req_in(req_in), .write_in(write_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .ack_out(ack_out),
  .rdata_out(rdata_out), .ext_sel_out(ext_sel_out),
  .ext_addr_out(ext_addr_out), .system_control_out(system_control_out),
  .pclk_en_out(pclk_en_out));

// [bench/test_system_control_unit.sv]
// self-checking bench for the system control unit
`timescale 1ns/1ns
module test_system_control_unit;
  localparam logic [31:0] B = 32'h0000_8000;
  logic clk_in, reset_n_in, req, wr, ack, ext_sel, ext_wr, a;
  logic [31:0] addr, wdata, rdata, ext_addr, ext_wdata, q, d;
  logic [7:0] system_control;
  logic [1:0] pclk;
  logic [15:0] crc;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int seed = 88838;
  int n0 = 0;
  int n1 = 0;
  scu_system_control scu_system_control_i (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .req_in(req), .write_in(wr), .addr_in(addr),
    .wdata_in(wdata), .ack_out(ack), .rdata_out(rdata),
    .ext_sel_out(ext_sel), .ext_write_out(ext_wr), .ext_addr_out(ext_addr),
    .ext_wdata_out(ext_wdata), .system_control_out(system_control),
    .pclk_en_out(pclk));
  scu_bus_master scu_bus_master_i (.clk_in(clk_in), .ack_in(ack),
    .rdata_in(rdata), .req_out(req), .write_out(wr), .addr_out(addr),
    .wdata_out(wdata));
  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic rd(input logic [31:0] ad, input logic [31:0] e);
    scu_bus_master_i.access(1'b0, ad, 32'h0, a, q);
    chk(32'h1, {31'h0, a});
    chk(e, q);
  endtask
  task automatic wrt(input logic [31:0] ad, input logic [31:0] v);
    scu_bus_master_i.access(1'b1, ad, v, a, q);
    chk(32'h1, {31'h0, a});
  endtask
  // bench model of the byte step, msb first
  function automatic logic [15:0] step(input logic [15:0] c,
    input logic [7:0] b);
    c = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++)
      c = c[15] ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
    return c;
  endfunction
  task automatic report_and_stop();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    reset_n_in = 1'b0;
    repeat (20) @(posedge clk_in);
    @(negedge clk_in);
    reset_n_in = 1'b1;
    rd(B + 32'h3c, 32'h4);
    rd(B, 32'h0);
    rd(B + 32'h4, 32'hffff);
    rd(B + 32'h34, 32'h1234);
    rd(B + 32'h38, 32'h1);
    rd(B + 32'hfc, 32'h4);
    rd(B + 32'h7c, 32'h4);
    wrt(B + 32'h3c, 32'hffff_ffff);
    rd(B + 32'h3c, 32'h4);
    rd(B + 32'h10, 32'h0);
    rd(B + 32'h8, 32'h0);
    $display("identity test done");
    repeat (4)
    begin
      d = $random(seed);
      wrt(B, d);
      chk({24'h0, d[7:0]}, {24'h0, system_control});
      rd(B, {24'h0, d[7:0]});
    end
    reset_n_in = 1'b0;
    @(negedge clk_in);
    reset_n_in = 1'b1;
    rd(B, 32'h0);
    chk(32'h0, {24'h0, system_control});
    $display("control test done");
    d = $random(seed);
    crc = d[15:0];
    wrt(B + 32'h4, d);
    rd(B + 32'h4, {16'h0, crc});
    repeat (16)
    begin
      d = $random(seed);
      crc = step(crc, d[7:0]);
      wrt(B + 32'h8, d);
      rd(B + 32'h4, {16'h0, crc});
    end
    $display("checksum test done");
    scu_bus_master_i.access(1'b1, 32'h0001_0010, 32'h55, a, q);
    chk(32'h3, {30'h0, ext_sel, ext_wr});
    chk(32'h0, {31'h0, a});
    chk(32'h10, ext_addr);
    chk(32'h55, ext_wdata);
    scu_bus_master_i.access(1'b0, 32'h0001_ff20, 32'h0, a, q);
    chk(32'h2, {30'h0, ext_sel, ext_wr});
    chk(32'hff20, ext_addr);
    scu_bus_master_i.access(1'b0, 32'h0002_0000, 32'h0, a, q);
    chk(32'h0, {30'h0, a, ext_sel});
    repeat (8)
    begin
      @(negedge clk_in);
      n0 += pclk[0];
      n1 += pclk[1];
    end
    chk(32'h4, n0);
    chk(32'h2, n1);
    $display("decode and divider test done");
    report_and_stop();
  end
endmodule // test_system_control_unit

// [design/scu_clock_divider.sv]
// one-cycle enable pulse every DIVISOR system clocks
`timescale 1ns/1ns
module scu_clock_divider
#(
  parameter int DIVISOR = 2
)
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  output logic tick_out
);

  localparam int CW = (DIVISOR > 1) ? $clog2(DIVISOR) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIVISOR - 1);

  logic [CW-1:0] count_reg;

  // refused at elaboration: a zero divisor has no period
  if (DIVISOR < 1)
  begin : bad_divisor
    $error("scu_clock_divider: divisor must be at least 1");
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      count_reg <= '0;
      tick_out <= 1'b0;
    end
    else
    begin
      // R11
      tick_out <= (count_reg == LAST);
      count_reg <= (count_reg == LAST) ? '0 : count_reg + 1'b1;
    end
  end

endmodule // scu_clock_divider

// [design/scu_system_control.sv]
// system control register unit: control, checksum, identification
`timescale 1ns/1ns
`include "scu_defs.svh"
module scu_system_control
  import scu_pkg::*;
#(
  parameter logic [31:0] UNIT_BASE = 32'h0000_8000,
  parameter int UNIT_REGION_WIDTH = 8,
  parameter logic [31:0] EXT_BASE = 32'h0001_0000,
  parameter int EXT_REGION_WIDTH = 16,
  parameter logic [15:0] CHECKSUM_POLY = `SCU_CHECKSUM_POLY,
  parameter bit CHECKSUM_LSB_FIRST = 1'b0,
  // arbitrary value
  parameter logic [31:0] DETECTION_WORD = 32'h0000_1234,
  // arbitrary value
  parameter logic [15:0] SYSTEM_TYPE = 16'h0001,
  // arbitrary value
  parameter logic [31:0] HW_REVISION = 32'h0000_0004,
  // arbitrary value, kept for simulation builds only
  parameter logic [31:0] SIM_REVISION = 32'h0000_fe10,
  parameter bit SIM_BUILD = 1'b0,
  parameter int NUM_PCLK = 2,
  parameter int PCLK_DIVISOR [NUM_PCLK] = '{2, 4},
  parameter int REF_CLOCK_HZ = 50000000,
  parameter int PLL_MUL = 1,
  parameter int PLL_DIV = 1
)
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic req_in,
  input wire logic write_in,
  input wire logic [31:0] addr_in,
  input wire logic [31:0] wdata_in,
  output logic ack_out,
  output logic [31:0] rdata_out,
  output logic ext_sel_out,
  output logic ext_write_out,
  output logic [31:0] ext_addr_out,
  output logic [31:0] ext_wdata_out,
  output logic [7:0] system_control_out,
  output logic [NUM_PCLK-1:0] pclk_en_out
);

  // ---------------------------------------------------------------
  // configuration checks
  // ---------------------------------------------------------------
  localparam longint SYSCLK_HZ =
    longint'(REF_CLOCK_HZ) * PLL_MUL / PLL_DIV; // R12
  localparam logic [31:0] REVISION_WORD =
    SIM_BUILD ? SIM_REVISION : HW_REVISION;

  // checks refuse the build at elaboration, not at run time
  if (PLL_MUL < 1 || PLL_DIV < 1)
  begin : bad_pll_factors
    $error("scu_system_control: pll factors must be at least 1");
  end
  if (SYSCLK_HZ != `SCU_SYSCLK_HZ)
  begin : bad_pll_result
    $error("scu_system_control: pll result differs from clk_in rate");
  end
  if (!SIM_BUILD && HW_REVISION == SIM_REVISION)
  begin : bad_revision
    $error("scu_system_control: revision reserved for simulation"); // R10
  end
  if (UNIT_REGION_WIDTH < `SCU_MAP_WIDTH || UNIT_REGION_WIDTH > 31)
  begin : bad_unit_region
    $error("scu_system_control: unit region narrower than map");
  end
  if (EXT_REGION_WIDTH < 1 || EXT_REGION_WIDTH > 31)
  begin : bad_ext_region
    $error("scu_system_control: bad external region width");
  end
  if (NUM_PCLK < 1)
  begin : bad_pclk_count
    $error("scu_system_control: need at least one peripheral clock");
  end

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  localparam logic [31:0] UNIT_MASK = ~((32'h0000_0001 << UNIT_REGION_WIDTH)
    - 32'h0000_0001);
  localparam logic [31:0] EXT_MASK = ~((32'h0000_0001 << EXT_REGION_WIDTH)
    - 32'h0000_0001);

  logic unit_hit;
  logic ext_hit;
  logic [`SCU_MAP_WIDTH-1:0] offset;
  scu_reg_sel_t reg_sel;

  // bits between map width and region width alias onto the map
  assign unit_hit = req_in && ((addr_in & UNIT_MASK) == UNIT_BASE); // R1
  assign offset = addr_in[`SCU_MAP_WIDTH-1:0]; // R9
  assign ext_hit = req_in && ((addr_in & EXT_MASK) == EXT_BASE); // R2

  always_comb
  begin
    reg_sel = scu_reg_none;
    if (unit_hit)
    begin
      unique case (offset)
        `SCU_OFS_SYSTEM_CONTROL: reg_sel = scu_reg_system_control;
        `SCU_OFS_CHECKSUM: reg_sel = scu_reg_checksum;
        `SCU_OFS_CHECKSUM_BYTE_IN: reg_sel = scu_reg_checksum_byte_in;
        `SCU_OFS_DETECTION_WORD: reg_sel = scu_reg_detection_word;
        `SCU_OFS_SYSTEM_TYPE_INFO: reg_sel = scu_reg_system_type_info;
        `SCU_OFS_HARDWARE_REVISION: reg_sel = scu_reg_hardware_revision;
        default: reg_sel = scu_reg_none;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checksum byte step
  // ---------------------------------------------------------------
  function automatic logic [15:0] crc_byte_step(input logic [15:0] crc,
    input logic [7:0] data);
    logic [15:0] c;
    logic fb;
    c = crc;
    for (int i = 0; i < 8; i++)
    begin
      fb = c[15] ^ (CHECKSUM_LSB_FIRST ? data[i] : data[7-i]); // R5
      c = {c[14:0], 1'b0} ^ (fb ? CHECKSUM_POLY : 16'h0000);
    end
    return c;
  endfunction

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [15:0] checksum_reg;

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      system_control_out <= `SCU_SYSTEM_CONTROL_RESET;
    else if (write_in && reg_sel == scu_reg_system_control)
      system_control_out <= wdata_in[7:0];
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      checksum_reg <= `SCU_CHECKSUM_RESET;
    else if (write_in && reg_sel == scu_reg_checksum)
      checksum_reg <= wdata_in[15:0]; // R3
    else if (write_in && reg_sel == scu_reg_checksum_byte_in)
      checksum_reg <= crc_byte_step(checksum_reg, wdata_in[7:0]); // R4
  end

  // ---------------------------------------------------------------
  // bus answer
  // ---------------------------------------------------------------
  // narrow registers read zero above their width; ids are constants
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      ack_out <= 1'b0;
      rdata_out <= 32'h0000_0000;
    end
    else
    begin
      ack_out <= unit_hit;
      if (unit_hit && !write_in)
      begin
        unique case (reg_sel)
          scu_reg_system_control:
            rdata_out <= {24'h00_0000, system_control_out};
          scu_reg_checksum:
            rdata_out <= {16'h0000, checksum_reg}; // R3
          scu_reg_detection_word:
            rdata_out <= DETECTION_WORD; // R6
          scu_reg_system_type_info:
            rdata_out <= {16'h0000, SYSTEM_TYPE}; // R7
          scu_reg_hardware_revision:
            rdata_out <= REVISION_WORD; // R8
          scu_reg_checksum_byte_in, scu_reg_none:
            rdata_out <= 32'h0000_0000;
        endcase
      end
      else
        rdata_out <= 32'h0000_0000;
    end
  end

  // external peripherals see an offset within their range only
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      ext_sel_out <= 1'b0;
      ext_write_out <= 1'b0;
      ext_addr_out <= 32'h0000_0000;
      ext_wdata_out <= 32'h0000_0000;
    end
    else
    begin
      ext_sel_out <= ext_hit; // R2
      ext_write_out <= ext_hit && write_in;
      ext_addr_out <= addr_in & ~EXT_MASK; // R2
      ext_wdata_out <= wdata_in;
    end
  end

  // ---------------------------------------------------------------
  // peripheral clock enables
  // ---------------------------------------------------------------
  // enables rather than gated clocks keep one clock domain
  generate
    for (genvar g = 0; g < NUM_PCLK; g++)
    begin : gen_pclk
      scu_clock_divider
      #(
        .DIVISOR(PCLK_DIVISOR[g])
      )
      scu_clock_divider_i
      (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .tick_out(pclk_en_out[g]) // R11
      );
    end
  endgenerate

endmodule // scu_system_control

// [inc/scu_defs.svh]
// constants and address map of the system control unit
// Contract
// R1: register address is unit base plus offset
// R2: external peripherals decode against external base only
// R3: offset 0x04 writes seed, reads checksum
// R4: byte written at 0x08 advances checksum
// R5: polynomial and bit order are parameters
// R6: detection word read-only at 0x34
// R7: system type code read-only at 0x38
// R8: hardware revision word last, at 0x3c
// R9: address bits above map width are ignored; code ignores only those below UNIT_REGION_WIDTH
// R10: simulation revision value never in hardware
// R11: peripheral clocks divide the system clock
// R12: system clock is reference times mul/div
// R13: firmware checks revision word at start-up
// R14: software masks upper bits of narrow reads
`ifndef SCU_DEFS_SVH
`define SCU_DEFS_SVH

// ---------------------------------------------------------------
// register offsets within the unit map
// ---------------------------------------------------------------
`define SCU_OFS_SYSTEM_CONTROL 6'h00
`define SCU_OFS_CHECKSUM 6'h04
`define SCU_OFS_CHECKSUM_BYTE_IN 6'h08
`define SCU_OFS_DETECTION_WORD 6'h34
`define SCU_OFS_SYSTEM_TYPE_INFO 6'h38
`define SCU_OFS_HARDWARE_REVISION 6'h3c

// ---------------------------------------------------------------
// widths and reset values
// ---------------------------------------------------------------
`define SCU_MAP_WIDTH 6
`define SCU_SYSTEM_CONTROL_WIDTH 8
`define SCU_CHECKSUM_WIDTH 16
`define SCU_SYSTEM_CONTROL_RESET 8'h00
`define SCU_CHECKSUM_RESET 16'hffff
`define SCU_CHECKSUM_POLY 16'h1021

// ---------------------------------------------------------------
// clocking
// ---------------------------------------------------------------
`define SCU_SYSCLK_HZ 50000000

`endif

// [inc/scu_pkg.sv]
// types shared by the system control unit files
package scu_pkg;

  typedef enum logic [2:0]
  {
    scu_reg_none,
    scu_reg_system_control,
    scu_reg_checksum,
    scu_reg_checksum_byte_in,
    scu_reg_detection_word,
    scu_reg_system_type_info,
    scu_reg_hardware_revision
  } scu_reg_sel_t;

endpackage
